// *** pkg/irdc_map.svh ***
/*
 * Register offsets, field positions, reset values and codes of the
 * pulse demodulation capture timer.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef IRDC_MAP_SVH
`define IRDC_MAP_SVH

// register offsets on the 4-bit register port
`define IRDC_A_NCTL    4'h0
`define IRDC_A_SCTL    4'h1
`define IRDC_A_WCTL    4'h2
`define IRDC_A_WRLD_LO 4'h3
`define IRDC_A_WRLD_HI 4'h4
`define IRDC_A_CAP_LO  4'h5
`define IRDC_A_CAP_HI  4'h6
`define IRDC_A_NRLD    4'h7
`define IRDC_A_IST     4'h8
`define IRDC_A_IMSK    4'h9

// narrow_control_reg fields
`define IRDC_NC_EN  7
`define IRDC_NC_TF  5
`define IRDC_NC_IM  1

// shared_control_reg fields
`define IRDC_SC_MODE  7
`define IRDC_SC_INSEL 6
`define IRDC_SC_EDG_H 5
`define IRDC_SC_EDG_L 4
`define IRDC_SC_SUB_H 3
`define IRDC_SC_SUB_L 2
`define IRDC_SC_RF    1
`define IRDC_SC_FF    0

// wide_control_reg fields
`define IRDC_WC_EN    7
`define IRDC_WC_FIRST 6
`define IRDC_WC_TF    5
`define IRDC_WC_CIM   2
`define IRDC_WC_TIM   1

// interrupt status / mask bits
`define IRDC_IS_CAP 0
`define IRDC_IS_WTO 1
`define IRDC_IS_NTO 2
`define IRDC_IS_W   3

// codes and values
`define IRDC_EDGE_FALL 2'h0
`define IRDC_EDGE_RISE 2'h1
`define IRDC_EDGE_BOTH 2'h2
`define IRDC_SUB_PP    2'h1
`define IRDC_BYTE_RST  8'h00
`define IRDC_BYTE_ONES 8'hFF
`define IRDC_WIDE_ONES 16'hFFFF
`define IRDC_WIDE_ZERO 16'h0000
`define IRDC_NAR_ZERO  8'h00
`define IRDC_IS_RST    3'h0

`endif

// *** pkg/irdc_pkg.sv ***
/*
 * Types shared by the capture timer modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package irdc_pkg;

    typedef enum logic [1:0] {
        IRDC_ST_WAIT,
        IRDC_ST_COUNT,
        IRDC_ST_HOLD
    } irdc_state_t;

    typedef struct packed {
        logic rise;
        logic fall;
    } irdc_edge_t;

endpackage

// *** logic/irdc_edge_sync.sv ***
/*
 * Synchroniser and edge detector for the selected demodulation input.
 * Assumes the input is asynchronous to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module irdc_edge_sync (
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire logic              pin_in,
    output irdc_pkg::irdc_edge_t   edge_ev
);

    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    // meta_ff feeds only sync_ff
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    // exactly one single-cycle pulse per edge
    assign edge_ev.rise = sync_ff & ~last_ff;
    assign edge_ev.fall = ~sync_ff & last_ff;

endmodule

`default_nettype wire

// *** logic/irdc_narrow_timer.sv ***
/*
 * Narrow 8-bit down counter with reload and terminal pulse.
 * Assumes run is driven by the enable bit held in the main module.
 */
`timescale 1ns/1ps
`default_nettype none
`include "irdc_map.svh"

module irdc_narrow_timer (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       run,
    input  wire logic [7:0] reload,
    output logic            term
);

    logic [7:0] cnt_ff;

    assign term = run && (cnt_ff == `IRDC_NAR_ZERO);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_ff <= `IRDC_BYTE_ONES;
        end else if (run) begin
            if (term) begin
                cnt_ff <= reload;
            end else begin
                cnt_ff <= cnt_ff - 8'h01;
            end
        end
    end

endmodule

`default_nettype wire

// *** logic/irdc_top.sv ***
/*
 * Pulse demodulation capture timer: wide counter with edge capture,
 * narrow counter, ping-pong alternation, registers and interrupt.
 * Assumes a register master that follows the plain strobe port
 * and a demodulation input that may be asynchronous.
 */
// Overview of operation
// - first qualifying edge captures, reloads, starts counting
// - later edges capture complemented count when bit clear
// - capture sets edge flag, masked capture interrupt
// - after capture wide counter reloads all ones
// - ping-pong hardware alternates the two enable bits
// - ping-pong sets each terminal flag at terminal count
// - edge-handling bit set: only first edge captures
// - mode bit selects transmit or demodulation
// - input select routes primary or alternate pin
// - wide terminal flag cleared by writing one
`timescale 1ns/1ps
`default_nettype none
`include "irdc_map.svh"

module irdc_top (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic [3:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       bus_wr,
    input  wire logic       bus_rd,
    output logic [7:0]      bus_rdata,
    input  wire logic       demod_input_primary,
    input  wire logic       demod_input_alt,
    output logic            irq,
    output logic            pin_int_line_b
);

    logic [7:0]            nctl_ff;
    logic [7:0]            sctl_ff;
    logic [7:0]            wctl_ff;
    logic [7:0]            wrld_lo_ff;
    logic [7:0]            wrld_hi_ff;
    logic [7:0]            nrld_ff;
    logic [7:0]            cap_lo_ff;
    logic [7:0]            cap_hi_ff;
    logic [15:0]           wcnt_ff;
    logic [2:0]            ist_ff;
    logic [2:0]            imsk_ff;
    logic [2:0]            nxt_ist;
    logic [7:0]            rdata_ff;
    logic                  irq_ff;
    logic                  pin_int_ff;
    irdc_pkg::irdc_state_t state_ff;
    irdc_pkg::irdc_edge_t  edge_ev;
    logic                  demod;
    logic                  pp_mode;
    logic                  sel_pin;
    logic                  qual;
    logic                  cap;
    logic                  w_run;
    logic                  w_term;
    logic                  n_term;

    function automatic logic wr_to(input logic [3:0] a);
        return bus_wr && (bus_addr == a);
    endfunction

    function automatic logic edge_match(input logic [1:0] sel,
                                        input irdc_pkg::irdc_edge_t ev);
        logic m;
        m = 1'b0;
        unique case (sel)
            `IRDC_EDGE_FALL: m = ev.fall;
            `IRDC_EDGE_RISE: m = ev.rise;
            `IRDC_EDGE_BOTH: m = ev.rise | ev.fall;
            default:         m = 1'b0;
        endcase
        return m;
    endfunction

    assign demod   = sctl_ff[`IRDC_SC_MODE];
    assign pp_mode = !demod &&
                     (sctl_ff[`IRDC_SC_SUB_H:`IRDC_SC_SUB_L] == `IRDC_SUB_PP);
    // switching the select may itself look like one edge
    assign sel_pin = sctl_ff[`IRDC_SC_INSEL] ? demod_input_alt
                                             : demod_input_primary;

    irdc_edge_sync u_sync (
        .clk_sys (clk_sys),
        .srst    (srst),
        .pin_in  (sel_pin),
        .edge_ev (edge_ev)
    );

    irdc_narrow_timer u_narrow (
        .clk_sys (clk_sys),
        .srst    (srst),
        .run     (nctl_ff[`IRDC_NC_EN]),
        .reload  (nrld_ff),
        .term    (n_term)
    );

    assign qual = edge_match(sctl_ff[`IRDC_SC_EDG_H:`IRDC_SC_EDG_L], edge_ev);
    // hold state drops all later edges
    assign cap    = demod && wctl_ff[`IRDC_WC_EN] && qual &&
                    (state_ff != irdc_pkg::IRDC_ST_HOLD);
    // in demodulation the counter idles until the first edge
    assign w_run  = wctl_ff[`IRDC_WC_EN] &&
                    (!demod || state_ff != irdc_pkg::IRDC_ST_WAIT);
    assign w_term = w_run && !cap && (wcnt_ff == `IRDC_WIDE_ZERO);

    // capture state
    always_ff @(posedge clk_sys) begin
        if (srst || !demod || !wctl_ff[`IRDC_WC_EN]) begin
            state_ff <= irdc_pkg::IRDC_ST_WAIT;
        end else begin
            unique case (state_ff)
                irdc_pkg::IRDC_ST_WAIT: begin
                    if (qual) begin
                        state_ff <= wctl_ff[`IRDC_WC_FIRST] ?
                                    irdc_pkg::IRDC_ST_HOLD :
                                    irdc_pkg::IRDC_ST_COUNT;
                    end
                end
                irdc_pkg::IRDC_ST_COUNT: state_ff <= irdc_pkg::IRDC_ST_COUNT;
                irdc_pkg::IRDC_ST_HOLD:  state_ff <= irdc_pkg::IRDC_ST_HOLD;
            endcase
        end
    end

    // wide counter
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wcnt_ff <= `IRDC_WIDE_ONES;
        end else if (cap) begin
            wcnt_ff <= `IRDC_WIDE_ONES;
        end else if (w_run) begin
            if (w_term) begin
                // software keeps these at all ones in demodulation
                wcnt_ff <= {wrld_hi_ff, wrld_lo_ff};
            end else begin
                wcnt_ff <= wcnt_ff - 16'h0001;
            end
        end
    end

    // capture registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cap_lo_ff <= `IRDC_BYTE_RST;
            cap_hi_ff <= `IRDC_BYTE_RST;
        end else if (cap) begin
            {cap_hi_ff, cap_lo_ff} <= ~wcnt_ff;
        end
    end

    // reload registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wrld_lo_ff <= `IRDC_BYTE_ONES;
            wrld_hi_ff <= `IRDC_BYTE_ONES;
            nrld_ff    <= `IRDC_BYTE_ONES;
        end else begin
            if (wr_to(`IRDC_A_WRLD_LO)) begin
                wrld_lo_ff <= bus_wdata;
            end
            if (wr_to(`IRDC_A_WRLD_HI)) begin
                wrld_hi_ff <= bus_wdata;
            end
            if (wr_to(`IRDC_A_NRLD)) begin
                nrld_ff <= bus_wdata;
            end
        end
    end

    // narrow control: later assignments win, so hardware beats software
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            nctl_ff <= `IRDC_BYTE_RST;
        end else begin
            if (wr_to(`IRDC_A_NCTL)) begin
                nctl_ff <= bus_wdata;
                nctl_ff[`IRDC_NC_TF] <= nctl_ff[`IRDC_NC_TF] &
                                        ~bus_wdata[`IRDC_NC_TF];
            end
            if (n_term) begin
                nctl_ff[`IRDC_NC_TF] <= 1'b1;
            end
            if (pp_mode && n_term) begin
                nctl_ff[`IRDC_NC_EN] <= 1'b0;
            end
            if (pp_mode && w_term) begin
                nctl_ff[`IRDC_NC_EN] <= 1'b1;
            end
        end
    end

    // wide control
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wctl_ff <= `IRDC_BYTE_RST;
        end else begin
            if (wr_to(`IRDC_A_WCTL)) begin
                wctl_ff <= bus_wdata;
                wctl_ff[`IRDC_WC_TF] <= wctl_ff[`IRDC_WC_TF] &
                                        ~bus_wdata[`IRDC_WC_TF];
            end
            if (w_term) begin
                wctl_ff[`IRDC_WC_TF] <= 1'b1;
            end
            if (pp_mode && w_term) begin
                wctl_ff[`IRDC_WC_EN] <= 1'b0;
            end
            if (pp_mode && n_term) begin
                wctl_ff[`IRDC_WC_EN] <= 1'b1;
            end
        end
    end

    // shared control with write-one-clear edge flags
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sctl_ff <= `IRDC_BYTE_RST;
        end else begin
            if (wr_to(`IRDC_A_SCTL)) begin
                sctl_ff <= bus_wdata;
                sctl_ff[`IRDC_SC_RF] <= sctl_ff[`IRDC_SC_RF] &
                                        ~bus_wdata[`IRDC_SC_RF];
                sctl_ff[`IRDC_SC_FF] <= sctl_ff[`IRDC_SC_FF] &
                                        ~bus_wdata[`IRDC_SC_FF];
            end
            if (cap && edge_ev.rise) begin
                sctl_ff[`IRDC_SC_RF] <= 1'b1;
            end
            if (cap && edge_ev.fall) begin
                sctl_ff[`IRDC_SC_FF] <= 1'b1;
            end
        end
    end

    // interrupt status: read clears, a new event in the same cycle stays
    always_comb begin
        nxt_ist = ist_ff;
        if (bus_rd && bus_addr == `IRDC_A_IST) begin
            nxt_ist = `IRDC_IS_RST;
        end
        if (cap && wctl_ff[`IRDC_WC_CIM]) begin
            nxt_ist[`IRDC_IS_CAP] = 1'b1;
        end
        if (w_term && wctl_ff[`IRDC_WC_TIM]) begin
            nxt_ist[`IRDC_IS_WTO] = 1'b1;
        end
        if (n_term && nctl_ff[`IRDC_NC_IM]) begin
            nxt_ist[`IRDC_IS_NTO] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ist_ff <= `IRDC_IS_RST;
            irq_ff <= 1'b0;
        end else begin
            ist_ff <= nxt_ist;
            irq_ff <= |(nxt_ist & imsk_ff);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            imsk_ff <= `IRDC_IS_RST;
        end else if (wr_to(`IRDC_A_IMSK)) begin
            imsk_ff <= bus_wdata[`IRDC_IS_W-1:0];
        end
    end

    // pin interrupt line follows captures through the primary input
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_int_ff <= 1'b0;
        end else begin
            pin_int_ff <= cap && !sctl_ff[`IRDC_SC_INSEL];
        end
    end

    // read data valid in the cycle after the strobe only
    always_ff @(posedge clk_sys) begin
        if (srst || !bus_rd) begin
            rdata_ff <= `IRDC_BYTE_RST;
        end else begin
            unique case (bus_addr)
                `IRDC_A_NCTL:    rdata_ff <= nctl_ff;
                `IRDC_A_SCTL:    rdata_ff <= sctl_ff;
                `IRDC_A_WCTL:    rdata_ff <= wctl_ff;
                `IRDC_A_WRLD_LO: rdata_ff <= wrld_lo_ff;
                `IRDC_A_WRLD_HI: rdata_ff <= wrld_hi_ff;
                `IRDC_A_CAP_LO:  rdata_ff <= cap_lo_ff;
                `IRDC_A_CAP_HI:  rdata_ff <= cap_hi_ff;
                `IRDC_A_NRLD:    rdata_ff <= nrld_ff;
                `IRDC_A_IST:     rdata_ff <= {5'h00, ist_ff};
                `IRDC_A_IMSK:    rdata_ff <= {5'h00, imsk_ff};
                default:         rdata_ff <= `IRDC_BYTE_RST;
            endcase
        end
    end

    assign bus_rdata      = rdata_ff;
    assign irq            = irq_ff;
    assign pin_int_line_b = pin_int_ff;

endmodule

`default_nettype wire

// *** tb/irdc_pulse_src.sv ***
/*
 * Remote pulse source feeding the two demodulation input pins.
 * Assumes the bench sets the wanted levels just after a clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module irdc_pulse_src (
    input  wire logic clk_sys,
    input  wire logic lvl_pri,
    input  wire logic lvl_alt,
    output logic      demod_input_primary = 1'b0,
    output logic      demod_input_alt = 1'b0
);
    // pins move mid-cycle, a fixed 1.3 ns after each rising clock edge, as a remote sender does
    always @(posedge clk_sys) begin
        demod_input_primary <= #1.3 lvl_pri;
        demod_input_alt     <= #1.3 lvl_alt;
    end
endmodule

`default_nettype wire

// *** tb/irdc_assertions.sv ***
/*
 * Port-level checker for the capture timer.
 * Assumes it is bound to irdc_top and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module irdc_assertions (
    input wire logic       clk_sys,
    input wire logic       srst,
    input wire logic [3:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic       bus_wr,
    input wire logic       bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic       demod_input_primary,
    input wire logic       demod_input_alt,
    input wire logic       irq,
    input wire logic       pin_int_line_b
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    logic [7:0] sctl_ff;
    logic [7:0] msk_ff;
    logic       last_ff;
    logic [3:0] gap_ff;

    // shadows of the select and mask registers, built from bus writes
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sctl_ff <= 8'h00;
            msk_ff  <= 8'h00;
        end else if (bus_wr && bus_addr == 4'h1) begin
            sctl_ff <= bus_wdata;
        end else if (bus_wr && bus_addr == 4'h9) begin
            msk_ff <= {5'h00, bus_wdata[2:0]};
        end
    end

    // cycles since the primary pin last moved, saturating
    always_ff @(posedge clk_sys) begin
        last_ff <= demod_input_primary;
        if (srst) gap_ff <= 4'hF;
        else if (demod_input_primary != last_ff) gap_ff <= 4'h0;
        else if (gap_ff != 4'hF) gap_ff <= gap_ff + 4'h1;
    end

    chk_reset_quiet: assert property (@(posedge clk_sys) disable iff (1'b0)
        srst |=> !irq && !pin_int_line_b && bus_rdata == 8'h00)
        else $error("outputs not quiet after reset");
    chk_rdata_quiet: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data outside its cycle");
    chk_unmapped_zero: assert property ($past(bus_rd) && $past(bus_addr) > 4'h9
        |-> bus_rdata == 8'h00) else $error("unmapped read not zero");
    chk_mask_readback: assert property (bus_rd && bus_addr == 4'h9
        |=> bus_rdata == $past(msk_ff)) else $error("mask readback wrong");
    chk_pint_single: assert property (pin_int_line_b |=> !pin_int_line_b)
        else $error("pin interrupt longer than one cycle");
    chk_pint_cause: assert property (pin_int_line_b |-> gap_ff < 4'h8)
        else $error("pin interrupt without a primary edge");
    chk_pint_route: assert property (pin_int_line_b |-> sctl_ff[7] && !sctl_ff[6])
        else $error("pin interrupt in wrong mode or input");
    chk_irq_masked: assert property (msk_ff == 8'h00 && $past(msk_ff, 3) == 8'h00
        |-> !irq) else $error("interrupt while fully masked");
    chk_irq_cause: assert property ($rose(irq) |-> msk_ff != 8'h00)
        else $error("interrupt rose with no mask bit");

    cover property (pin_int_line_b);
    cover property ($rose(irq));
    cover property (bus_rd && bus_addr == 4'h5);
endmodule

bind irdc_top irdc_assertions u_chk (
    .clk_sys             (clk_sys),
    .srst                (srst),
    .bus_addr            (bus_addr),
    .bus_wdata           (bus_wdata),
    .bus_wr              (bus_wr),
    .bus_rd              (bus_rd),
    .bus_rdata           (bus_rdata),
    .demod_input_primary (demod_input_primary),
    .demod_input_alt     (demod_input_alt),
    .irq                 (irq),
    .pin_int_line_b      (pin_int_line_b)
);

`default_nettype wire

// *** tb/tb_top.sv ***
/*
 * Self-checking bench: reset values, capture timing, first-edge
 * hold, flags and interrupt, ping-pong hand-over.
 * Assumes the checker is bound to the design by its own file.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        clk_sys;
    logic        srst = 1'b1;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic [3:0]  bus_addr = 4'h0;
    logic [7:0]  bus_wdata = 8'h00;
    logic [7:0]  bus_rdata;
    logic        lvl_pri = 1'b0;
    logic        lvl_alt = 1'b0;
    logic        irq;
    logic        pin_int_line_b;
    logic [7:0]  d;
    logic [7:0]  lo;
    wire         pri;
    wire         alt;
    int          failures = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          pints = 0;
    logic [11:0] rows [11] = '{12'h000, 12'h100, 12'h200, 12'h3FF, 12'h4FF,
                               12'h500, 12'h600, 12'h800, 12'h900, 12'hA00, 12'hF00};

    irdc_pulse_src src (
        .clk_sys             (clk_sys),
        .lvl_pri             (lvl_pri),
        .lvl_alt             (lvl_alt),
        .demod_input_primary (pri),
        .demod_input_alt     (alt)
    );

    irdc_top uut (
        .clk_sys             (clk_sys),
        .srst                (srst),
        .bus_addr            (bus_addr),
        .bus_wdata           (bus_wdata),
        .bus_wr              (bus_wr),
        .bus_rd              (bus_rd),
        .bus_rdata           (bus_rdata),
        .demod_input_primary (pri),
        .demod_input_alt     (alt),
        .irq                 (irq),
        .pin_int_line_b      (pin_int_line_b)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic report_and_stop;
        if (failures == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // whole run needs about 72000 cycles, mostly the first wide pass from all ones
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (pin_int_line_b === 1'b1) pints <= pints + 1;
        if (cyc == 80000) begin
            failures++;
            report_and_stop;
        end
    end

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic do_reset;
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        bus_addr  <= a;
        bus_wdata <= v;
        bus_wr    <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask

    task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        rd(a);
        chk(d & m, e);
    endtask

    // sets a pin level, then lets exactly n edges pass in all
    task automatic move(input logic p, input logic v, input int n);
        @(posedge clk_sys);
        if (p) lvl_pri <= v;
        else lvl_alt <= v;
        repeat (n - 1) @(posedge clk_sys);
    endtask

    initial begin
        do_reset;
        wr(4'hF, 8'h55);
        foreach (rows[i]) rc(rows[i][11:8], 8'hFF, rows[i][7:0]);
        wr(4'h3, 8'hFF);
        wr(4'h4, 8'hFF);
        wr(4'h1, 8'h90);
        wr(4'h2, 8'h84);
        wr(4'h9, 8'h01);
        // rise, ignored fall, rise 0x1234 edges after the first
        move(1'b1, 1'b1, 100);
        move(1'b1, 1'b0, 16'h1234 - 100);
        move(1'b1, 1'b1, 10);
        #1 chk({7'h00, irq}, 8'h01);
        rc(4'h5, 8'hFF, 8'h33);
        rc(4'h6, 8'hFF, 8'h12);
        rc(4'h1, 8'hFF, 8'h92);
        wr(4'h1, 8'h90);
        rc(4'h1, 8'hFF, 8'h92);
        wr(4'h1, 8'h92);
        rc(4'h1, 8'hFF, 8'h90);
        rc(4'h8, 8'hFF, 8'h01);
        rc(4'h8, 8'hFF, 8'h00);
        repeat (3) @(posedge clk_sys);
        #1 chk({7'h00, irq}, 8'h00);
        wr(4'h1, 8'hA0);
        move(1'b1, 1'b0, 10);
        rc(4'h1, 8'hFF, 8'hA1);
        chk(pints[7:0], 8'h03);

        // alternate input, falling code, first edge only, mask clear
        do_reset;
        wr(4'h3, 8'hFF);
        wr(4'h4, 8'hFF);
        wr(4'h1, 8'hC0);
        wr(4'h2, 8'hC4);
        move(1'b0, 1'b1, 20);
        move(1'b0, 1'b0, 50);
        move(1'b0, 1'b1, 50);
        move(1'b0, 1'b0, 50);
        rc(4'h5, 8'hFF, 8'h00);
        rc(4'h6, 8'hFF, 8'h00);
        rc(4'h1, 8'hFF, 8'hC1);
        chk({7'h00, irq}, 8'h00);
        rc(4'h8, 8'hFF, 8'h01);
        chk(pints[7:0], 8'h03);

        // ping-pong: narrow reload 0x80, wide reload 0x0100
        do_reset;
        wr(4'h1, 8'h04);
        wr(4'h7, 8'h80);
        wr(4'h3, 8'h00);
        wr(4'h4, 8'h01);
        wr(4'h0, 8'h80);
        d = 8'h80;
        for (int k = 0; k < 400 && d[7]; k++) rd(4'h0);
        repeat (100) @(posedge clk_sys);
        rc(4'h0, 8'hA0, 8'h20);
        rc(4'h2, 8'hA0, 8'h80);
        // pin edges in transmit mode must not capture
        move(1'b1, 1'b1, 10);
        move(1'b1, 1'b0, 10);
        rc(4'h5, 8'hFF, 8'h00);
        rc(4'h1, 8'hFF, 8'h04);
        // wide count starts from all ones after reset, so the first pass is long
        d = 8'h80;
        for (int k = 0; k < 40000 && d[7]; k++) rd(4'h2);
        rc(4'h0, 8'hA0, 8'hA0);
        rc(4'h2, 8'hA0, 8'h20);
        wr(4'h0, 8'h20);
        wr(4'h2, 8'h00);
        rc(4'h2, 8'h20, 8'h20);
        wr(4'h2, 8'h20);
        rc(4'h2, 8'h20, 8'h00);
        report_and_stop;
    end
endmodule

`default_nettype wire
